// *** common/ahr_pkg.sv ***
// constants, types and trigger table of the host bus ready port
package ahr_pkg;
    localparam int BUS_W   = 12;
    localparam int CTRL_W  = 10;
    localparam int CNT_W   = 5;
    localparam int SYNC_W  = 5;

    // bus bit that picks control register 0 or 1 on a store
    localparam int REG_SEL_BIT = 10;

    // control register 1 field positions
    localparam int TRIG_LO_BIT = 2;
    localparam int TRIG_HI_BIT = 3;
    localparam int DATA_T_BIT  = 4;
    localparam int DATA_P_BIT  = 5;
    localparam int DIR_SEL_BIT = 6;

    localparam logic [CTRL_W-1:0] CTRL0_RESET = 10'h000;
    localparam logic [CTRL_W-1:0] CTRL1_RESET = 10'h030;
    localparam logic [BUS_W-1:0]  DATA_RESET  = 12'h000;
    localparam logic [CNT_W-1:0]  CNT_ZERO    = 5'h00;
    localparam logic [CNT_W-1:0]  CNT_ONE     = 5'h01;

    // clock and internal oscillator half period
    localparam int CLK_MHZ      = 125;
    localparam int OSC_HALF_NS  = 50;
    localparam int OSC_HALF_RAW = (OSC_HALF_NS * CLK_MHZ) / 1000;
    localparam int OSC_HALF_CYC = (OSC_HALF_RAW < 1) ? 1 : OSC_HALF_RAW;
    localparam logic [7:0] OSC_HALF_CNT = 8'(OSC_HALF_CYC);
    localparam logic [7:0] PULSE_ZERO   = 8'h00;
    localparam logic [7:0] PULSE_ONE    = 8'h01;

    // threshold in stored values, indexed by {channels-1, trigger select}
    localparam logic [CNT_W-1:0] TRIG_TABLE [16] = '{
        5'h01, 5'h04, 5'h08, 5'h0e,
        5'h02, 5'h04, 5'h08, 5'h0c,
        5'h03, 5'h06, 5'h09, 5'h0c,
        5'h04, 5'h08, 5'h0c, 5'h0c
    };

    typedef struct packed {
        logic chip_select_low_n;
        logic chip_select_high;
        logic read_n;
        logic write_n;
        logic conversion_clock;
    } ahr_pins_s;

    // pin levels of an idle bus: selects off, both strobes high
    localparam ahr_pins_s PINS_IDLE = 5'h16;

    typedef enum logic [1:0] {
        RDY_ARMED    = 2'b00,
        RDY_LEVEL_ON = 2'b01,
        RDY_PULSE_ON = 2'b10,
        RDY_DRAIN    = 2'b11
    } ahr_ready_e;
endpackage

// *** core/ahr_skid_buf.sv ***
// two-entry buffer with valid/ready on both sides
`timescale 1ns/10ps
module ahr_skid_buf
    import ahr_pkg::*;
#(
    parameter int WIDTH = BUS_W
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] slot0;
    logic [WIDTH-1:0] slot1;
    logic [1:0]       count;
    logic [WIDTH-1:0] next_slot0;
    logic [WIDTH-1:0] next_slot1;
    logic [1:0]       next_count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = slot0;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        next_slot0 = slot0;
        next_slot1 = slot1;
        next_count = count;
        if (pop) begin
            next_slot0 = slot1;
        end
        if (push) begin
            if (count == 2'h0 || (count == 2'h1 && pop)) begin
                next_slot0 = in_data;
            end else begin
                next_slot1 = in_data;
            end
        end
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            slot0 <= '0;
            slot1 <= '0;
            count <= 2'h0;
        end else if (clk_en) begin
            slot0 <= next_slot0;
            slot1 <= next_slot1;
            count <= next_count;
        end
    end
endmodule

// *** core/ahr_host_port.sv ***
// asynchronous host port: strobe forming, control registers, sample-ready output
`timescale 1ns/10ps
module ahr_host_port
    import ahr_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              chip_select_low_n,
    input  wire logic              chip_select_high,
    input  wire logic              read_n,
    input  wire logic              write_n,
    input  wire logic              conversion_clock,
    input  wire logic [BUS_W-1:0]  data_in,
    output logic      [BUS_W-1:0]  data_out,
    output logic                   data_oe,
    input  wire logic              fifo_valid,
    output logic                   fifo_ready,
    input  wire logic [BUS_W-1:0]  fifo_data,
    input  wire logic [CNT_W-1:0]  fifo_count,
    input  wire logic [1:0]        channel_count,
    input  wire logic              continuous_mode,
    output logic      [CTRL_W-1:0] ctrl_reg0,
    output logic      [CTRL_W-1:0] ctrl_reg1,
    output logic      [1:0]        ctrl_written,
    output logic                   sample_ready_out
);
    //**********************************************************
    // pin synchronisers
    //**********************************************************
    ahr_pins_s pins_raw;
    ahr_pins_s pins_s1;
    ahr_pins_s pins_s2;
    ahr_pins_s pins_s3;
    ahr_pins_s pins_f;
    ahr_pins_s next_pins_f;
    logic [BUS_W-1:0] data_s1;
    logic [BUS_W-1:0] data_s2;
    logic [BUS_W-1:0] data_s3;
    logic [BUS_W-1:0] data_f;
    logic [BUS_W-1:0] next_data_f;

    assign pins_raw = '{chip_select_low_n: chip_select_low_n,
                        chip_select_high:  chip_select_high,
                        read_n:            read_n,
                        write_n:           write_n,
                        conversion_clock:  conversion_clock};

    // the bus word rides the same filter as the strobes, so the word taken
    // in the last active store cycle is the one the host held there
    always_comb begin
        next_data_f = data_f;
        for (int i = 0; i < BUS_W; i++) begin
            if (data_s2[i] == data_s3[i]) begin
                next_data_f[i] = data_s3[i];
            end
        end
    end

    // a change is accepted once second and third stage agree
    always_comb begin
        next_pins_f = pins_f;
        for (int i = 0; i < SYNC_W; i++) begin
            if (pins_s2[i] == pins_s3[i]) begin
                next_pins_f[i] = pins_s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // stages start at idle pin levels so no strobe edge follows reset
            pins_s1 <= PINS_IDLE;
            pins_s2 <= PINS_IDLE;
            pins_s3 <= PINS_IDLE;
            pins_f  <= PINS_IDLE;
            data_s1 <= DATA_RESET;
            data_s2 <= DATA_RESET;
            data_s3 <= DATA_RESET;
            data_f  <= DATA_RESET;
        end else if (clk_en) begin
            pins_s1 <= pins_raw;
            pins_s2 <= pins_s1;
            pins_s3 <= pins_s2;
            pins_f  <= next_pins_f;
            data_s1 <= data_in;
            data_s2 <= data_s1;
            data_s3 <= data_s2;
            data_f  <= next_data_f;
        end
    end

    //**********************************************************
    // internal fetch and store strobes
    //**********************************************************
    logic cs_ok;
    logic dir_mode;
    logic fetch_lvl;
    logic store_lvl;
    logic fetch_q;
    logic store_q;
    logic fetch_rise;
    logic store_fall;

    assign cs_ok    = !pins_f.chip_select_low_n && pins_f.chip_select_high;
    assign dir_mode = ctrl_reg1[DIR_SEL_BIT];

    always_comb begin
        if (dir_mode) begin
            // direction line: high reads, low writes; read input ignored
            fetch_lvl = cs_ok && pins_f.write_n;
            store_lvl = cs_ok && !pins_f.write_n;
        end else begin
            fetch_lvl = cs_ok && !pins_f.read_n && pins_f.write_n;
            store_lvl = cs_ok && !pins_f.write_n && pins_f.read_n;
        end
    end

    // one action per access: fetch acts on its start, store on its end
    assign fetch_rise = fetch_lvl && !fetch_q;
    assign store_fall = !store_lvl && store_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fetch_q <= 1'b0;
            store_q <= 1'b0;
        end else if (clk_en) begin
            fetch_q <= fetch_lvl;
            store_q <= store_lvl;
        end
    end

    //**********************************************************
    // control registers
    //**********************************************************
    logic [BUS_W-1:0]  wdata;
    logic [BUS_W-1:0]  next_wdata;
    logic [CTRL_W-1:0] next_ctrl0;
    logic [CTRL_W-1:0] next_ctrl1;
    logic [1:0]        next_written;

    always_comb begin
        next_wdata   = wdata;
        next_ctrl0   = ctrl_reg0;
        next_ctrl1   = ctrl_reg1;
        next_written = 2'h0;
        if (store_lvl) begin
            next_wdata = data_f;
        end
        if (store_fall) begin
            if (wdata[REG_SEL_BIT]) begin
                next_ctrl1   = wdata[CTRL_W-1:0];
                next_written = 2'h2;
            end else begin
                next_ctrl0   = wdata[CTRL_W-1:0];
                next_written = 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wdata        <= DATA_RESET;
            ctrl_reg0    <= CTRL0_RESET;
            ctrl_reg1    <= CTRL1_RESET;
            ctrl_written <= 2'h0;
        end else if (clk_en) begin
            wdata        <= next_wdata;
            ctrl_reg0    <= next_ctrl0;
            ctrl_reg1    <= next_ctrl1;
            ctrl_written <= next_written;
        end
    end

    //**********************************************************
    // fifo words onto the data bus
    //**********************************************************
    logic             buf_valid;
    logic [BUS_W-1:0] buf_data;
    logic [BUS_W-1:0] next_data_out;

    ahr_skid_buf #(
        .WIDTH (BUS_W)
    ) u_buf (
        .clk       (clk),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .in_valid  (fifo_valid),
        .in_ready  (fifo_ready),
        .in_data   (fifo_data),
        .out_valid (buf_valid),
        .out_ready (fetch_rise),
        .out_data  (buf_data)
    );

    // an empty buffer leaves the previous word on the bus; the fetch still counts as a read
    always_comb begin
        next_data_out = data_out;
        if (fetch_rise && buf_valid) begin
            next_data_out = buf_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_out <= DATA_RESET;
            data_oe  <= 1'b0;
        end else if (clk_en) begin
            data_out <= next_data_out;
            data_oe  <= fetch_lvl;
        end
    end

    //**********************************************************
    // sample-ready output
    //**********************************************************
    ahr_ready_e       rdy_state;
    ahr_ready_e       next_rdy_state;
    logic [CNT_W-1:0] reads_left;
    logic [CNT_W-1:0] next_reads_left;
    logic [7:0]       pulse_cnt;
    logic [7:0]       next_pulse_cnt;
    logic             conv_prev;
    logic             conv_edge;
    logic             pulse_type;
    logic             active_high;
    logic [CNT_W-1:0] threshold;
    logic             trig_met;
    logic             pulse_done;
    logic [CNT_W-1:0] left_after;
    logic             rdy_active;
    logic             next_ready_out;

    assign pulse_type  = ctrl_reg1[DATA_T_BIT];
    assign active_high = ctrl_reg1[DATA_P_BIT];
    assign threshold   = TRIG_TABLE[{channel_count, ctrl_reg1[TRIG_HI_BIT], ctrl_reg1[TRIG_LO_BIT]}];
    assign trig_met    = (fifo_count >= threshold);
    assign conv_edge   = (pins_f.conversion_clock != conv_prev);
    assign left_after  = fetch_rise && (reads_left != CNT_ZERO) ? reads_left - CNT_ONE : reads_left;
    // continuous: ends on the next conversion clock edge; single: oscillator count
    assign pulse_done  = continuous_mode ? conv_edge : (pulse_cnt == PULSE_ONE);

    // reads_left counts fetches from the assert on, the first one included
    always_comb begin
        next_rdy_state  = rdy_state;
        next_reads_left = left_after;
        next_pulse_cnt  = pulse_cnt;
        case (rdy_state)
            RDY_ARMED: begin
                next_reads_left = reads_left;
                if (trig_met && !pulse_type) begin
                    next_rdy_state  = RDY_LEVEL_ON;
                    next_reads_left = threshold;
                end else if (trig_met && (!continuous_mode || conv_edge)) begin
                    next_rdy_state  = RDY_PULSE_ON;
                    next_reads_left = threshold;
                    next_pulse_cnt  = OSC_HALF_CNT;
                end
            end
            RDY_LEVEL_ON: begin
                if (fetch_rise) begin
                    next_rdy_state = (left_after == CNT_ZERO) ? RDY_ARMED : RDY_DRAIN;
                end
            end
            RDY_PULSE_ON: begin
                if (pulse_cnt != PULSE_ZERO) begin
                    next_pulse_cnt = pulse_cnt - PULSE_ONE;
                end
                if (pulse_done) begin
                    next_pulse_cnt = PULSE_ZERO;
                    next_rdy_state = (left_after == CNT_ZERO) ? RDY_ARMED : RDY_DRAIN;
                end
            end
            RDY_DRAIN: begin
                if (left_after == CNT_ZERO) begin
                    next_rdy_state = RDY_ARMED;
                end
            end
            default: begin
                next_rdy_state  = RDY_ARMED;
                next_reads_left = CNT_ZERO;
                next_pulse_cnt  = PULSE_ZERO;
            end
        endcase
    end

    assign rdy_active     = (next_rdy_state == RDY_LEVEL_ON) || (next_rdy_state == RDY_PULSE_ON);
    assign next_ready_out = active_high ? rdy_active : !rdy_active;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdy_state        <= RDY_ARMED;
            reads_left       <= CNT_ZERO;
            pulse_cnt        <= PULSE_ZERO;
            conv_prev        <= 1'b0;
            sample_ready_out <= CTRL1_RESET[DATA_P_BIT] ? 1'b0 : 1'b1;
        end else if (clk_en) begin
            rdy_state        <= next_rdy_state;
            reads_left       <= next_reads_left;
            pulse_cnt        <= next_pulse_cnt;
            conv_prev        <= pins_f.conversion_clock;
            sample_ready_out <= next_ready_out;
        end
    end
endmodule

// *** verification/ahr_host_port_properties.sv ***
// concurrent checks on the host port boundary
`timescale 1ns/10ps
module ahr_host_port_properties
    import ahr_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              chip_select_low_n,
    input wire logic              chip_select_high,
    input wire logic              read_n,
    input wire logic              write_n,
    input wire logic [BUS_W-1:0]  data_in,
    input wire logic              data_oe,
    input wire logic              continuous_mode,
    input wire logic [CTRL_W-1:0] ctrl_reg0,
    input wire logic [CTRL_W-1:0] ctrl_reg1,
    input wire logic [1:0]        ctrl_written,
    input wire logic              sample_ready_out
);
    // ************************
    // helpers and properties
    // ************************
    logic       rdy_act;
    logic [3:0] idle_cnt;
    logic [3:0] next_idle_cnt;
    assign rdy_act = (sample_ready_out == ctrl_reg1[DATA_P_BIT]);
    // cycles since chip_select_high was last high
    always_comb begin
        next_idle_cnt = idle_cnt;
        if (chip_select_high) begin
            next_idle_cnt = 4'h0;
        end else if (idle_cnt != 4'hf) begin
            next_idle_cnt = idle_cnt + 4'h1;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            idle_cnt <= 4'h0;
        end else begin
            idle_cnt <= next_idle_cnt;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_fetch_cause;
        $rose(data_oe) |-> $past(chip_select_high && !chip_select_low_n && write_n
            && (ctrl_reg1[DIR_SEL_BIT] || !read_n), 3);
    endproperty
    a_fetch_cause: assert property (p_fetch_cause) else $error("fetch without valid select");
    property p_idle_quiet;
        idle_cnt >= 4'h9 |-> !data_oe && ctrl_written == 2'b00;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("bus driven while idle");
    property p_store0;
        ctrl_written[0] |-> ctrl_reg0 == $past(data_in[CTRL_W-1:0], 7)
            && !$past(data_in[REG_SEL_BIT], 7) && !$past(write_n, 7);
    endproperty
    a_store0: assert property (p_store0) else $error("register 0 store wrong");
    property p_store1;
        ctrl_written[1] |-> ctrl_reg1 == $past(data_in[CTRL_W-1:0], 7) && $past(data_in[REG_SEL_BIT], 7);
    endproperty
    a_store1: assert property (p_store1) else $error("register 1 store wrong");
    property p_only_store;
        !$stable({ctrl_reg1, ctrl_reg0}) |-> ctrl_written != 2'b00;
    endproperty
    a_only_store: assert property (p_only_store) else $error("register changed without store");
    property p_written_once;
        ctrl_written != 2'b00 |=> ctrl_written == 2'b00;
    endproperty
    a_written_once: assert property (p_written_once) else $error("store acted twice");
    property p_level_drop;
        $rose(data_oe) && !ctrl_reg1[DATA_T_BIT] && $past(rdy_act) |-> !rdy_act;
    endproperty
    a_level_drop: assert property (p_level_drop) else $error("level not dropped on read");
    property p_single_width;
        $rose(rdy_act) && ctrl_reg1[DATA_T_BIT] && !continuous_mode && ctrl_written == 2'b00
            |-> rdy_act [*6] ##1 !rdy_act;
    endproperty
    a_single_width: assert property (p_single_width) else $error("single pulse width wrong");
    property p_cont_width;
        $rose(rdy_act) && ctrl_reg1[DATA_T_BIT] && continuous_mode && ctrl_written == 2'b00
            |-> rdy_act [*8] ##[1:4] !rdy_act;
    endproperty
    a_cont_width: assert property (p_cont_width) else $error("continuous pulse width wrong");
endmodule

bind ahr_host_port ahr_host_port_properties i_ahr_host_port_properties (
    .clk(clk), .reset_n(reset_n), .chip_select_low_n(chip_select_low_n), .chip_select_high(chip_select_high),
    .read_n(read_n), .write_n(write_n), .data_in(data_in), .data_oe(data_oe), .continuous_mode(continuous_mode),
    .ctrl_reg0(ctrl_reg0), .ctrl_reg1(ctrl_reg1), .ctrl_written(ctrl_written), .sample_ready_out(sample_ready_out)
);

// *** verification/ahr_host_model.sv ***
// host processor model driving the asynchronous bus pins
`timescale 1ns/10ps
module ahr_host_model
    import ahr_pkg::*;
(
    input  wire logic             clk,
    output logic                  chip_select_low_n,
    output logic                  chip_select_high,
    output logic                  read_n,
    output logic                  write_n,
    output logic      [BUS_W-1:0] data_in,
    input  wire logic [BUS_W-1:0] data_out,
    input  wire logic             data_oe
);
    // ************************
    // bus access
    // ************************
    logic dir_mode = 1'b0;
    initial begin
        chip_select_low_n = 1'b1;
        chip_select_high = 1'b0;
        read_n = 1'b1;
        write_n = 1'b1;
        data_in = 12'h000;
    end
    // op 0 read, 1 write, 2 both strobes low; pins held 8 cycles, then 7 idle
    task automatic xfer(input logic [1:0] op, input logic [BUS_W-1:0] word, output logic [BUS_W-1:0] got);
        @(posedge clk);
        #1;
        chip_select_low_n = 1'b0;
        chip_select_high = 1'b1;
        write_n = (op == 2'h0);
        read_n = dir_mode || (op == 2'h1);
        data_in = (op == 2'h0) ? ~data_in : word;
        repeat (8) @(posedge clk);
        // an undriven bus reads back as garbage
        got = data_oe ? data_out : ~data_out;
        #1;
        chip_select_low_n = 1'b1;
        chip_select_high = 1'b0;
        write_n = 1'b1;
        read_n = 1'b1;
        data_in = ~data_in;
        repeat (7) @(posedge clk);
        #1;
    endtask
endmodule

// *** verification/ahr_host_port_bench.sv ***
// self-checking bench for the host port
`timescale 1ns/10ps
module ahr_host_port_bench
    import ahr_pkg::*;
;
    // ************************
    // stimulus and checks
    // ************************
    logic              clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              clk_en = 1'b1;
    logic              conversion_clock = 1'b0;
    logic              fifo_valid = 1'b0;
    logic              continuous_mode = 1'b0;
    logic              feed_en = 1'b0;
    logic              chip_select_low_n, chip_select_high, read_n, write_n, data_oe, fifo_ready, sample_ready_out;
    logic [BUS_W-1:0]  data_in, data_out, last;
    logic [BUS_W-1:0]  fifo_data = 12'h000;
    logic [CNT_W-1:0]  fifo_count = 5'h00;
    logic [1:0]        channel_count = 2'h0;
    logic [1:0]        ctrl_written;
    logic [CTRL_W-1:0] ctrl_reg0, ctrl_reg1;
    logic [BUS_W-1:0]  sent[$];
    int                mismatches = 0;
    int                tests_run = 0;

    ahr_host_port i_ahr_host_port (
        .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .chip_select_low_n(chip_select_low_n),
        .chip_select_high(chip_select_high), .read_n(read_n), .write_n(write_n), .conversion_clock(conversion_clock),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .fifo_valid(fifo_valid), .fifo_ready(fifo_ready),
        .fifo_data(fifo_data), .fifo_count(fifo_count), .channel_count(channel_count),
        .continuous_mode(continuous_mode), .ctrl_reg0(ctrl_reg0), .ctrl_reg1(ctrl_reg1),
        .ctrl_written(ctrl_written), .sample_ready_out(sample_ready_out)
    );
    ahr_host_model i_ahr_host_model (
        .clk(clk), .chip_select_low_n(chip_select_low_n), .chip_select_high(chip_select_high), .read_n(read_n),
        .write_n(write_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe)
    );

    initial begin
        forever begin
            #4 clk = ~clk;
        end
    end
    always begin
        repeat (10) @(posedge clk);
        #1;
        conversion_clock = ~conversion_clock;
    end
    // conversion side: offers random words, logs every accepted one
    always @(posedge clk) begin
        logic en;
        logic take;
        en = feed_en;
        take = !fifo_valid || fifo_ready || !en;
        if (fifo_valid && fifo_ready) begin
            sent.push_back(fifo_data);
        end
        #1;
        if (take) begin
            fifo_valid = en && ($urandom_range(0, 3) != 0);
            fifo_data = BUS_W'($urandom);
        end
    end

    task automatic check(input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk_rdy(input logic exp);
        check({11'h000, sample_ready_out}, {11'h000, exp});
    endtask
    task automatic rd_chk;
        logic [BUS_W-1:0] got;
        i_ahr_host_model.xfer(2'h0, 12'h000, got);
        last = sent.pop_front();
        check(got, last);
    endtask
    task automatic wr_reg(input logic sel, input logic [CTRL_W-1:0] v);
        logic [BUS_W-1:0] got;
        i_ahr_host_model.xfer(2'h1, {1'b0, sel, v}, got);
        check({2'b00, sel ? ctrl_reg1 : ctrl_reg0}, {2'b00, v});
    endtask
    task automatic do_reset;
        feed_en = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b0;
        sent.delete();
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b1;
        feed_en = 1'b1;
    endtask
    task automatic pulse_w(input logic pol, output int w);
        int n;
        n = 0;
        w = 0;
        while (sample_ready_out !== pol && n < 300) begin
            @(posedge clk);
            n++;
        end
        while (sample_ready_out === pol && w < 300) begin
            @(posedge clk);
            w++;
        end
    endtask

    initial begin
        #400000;
        mismatches++;
        close_out();
    end
    initial begin
        logic [BUS_W-1:0] got;
        logic [CNT_W-1:0] thr;
        logic [1:0]       sel;
        logic             pol;
        int               w;
        void'($urandom(79438));
        repeat (2) @(posedge clk);
        chk_rdy(1'b0);
        check({2'b00, ctrl_reg1}, 12'h030);
        check({2'b00, ctrl_reg0}, 12'h000);
        #1;
        reset_n = 1'b1;
        feed_en = 1'b1;
        repeat (12) @(posedge clk);
        check({11'h000, fifo_ready}, 12'h000);
        #1;
        feed_en = 1'b0;
        rd_chk();
        rd_chk();
        check({11'h000, fifo_ready}, 12'h001);
        // empty buffer: old word stays on the bus
        i_ahr_host_model.xfer(2'h0, 12'h000, got);
        check(got, last);
        i_ahr_host_model.xfer(2'h2, 12'h155, got);
        check({2'b00, ctrl_reg0}, 12'h000);
        // frozen clock enable: a store must leave no trace
        clk_en = 1'b0;
        i_ahr_host_model.xfer(2'h1, 12'h2ff, got);
        clk_en = 1'b1;
        check({2'b00, ctrl_reg0}, 12'h000);
        feed_en = 1'b1;
        repeat (3) wr_reg(1'b0, CTRL_W'($urandom));
        for (int t = 0; t < 8; t++) begin
            do_reset();
            pol = t[1];
            sel = 2'($urandom_range(0, 3));
            channel_count = 2'($urandom_range(0, 3));
            continuous_mode = t[2];
            thr = TRIG_TABLE[{channel_count, sel}];
            fifo_count = 5'h00;
            wr_reg(1'b1, {4'h0, pol, t[0], sel, 2'b00});
            fifo_count = thr - 5'h01;
            repeat (12) @(posedge clk);
            chk_rdy(~pol);
            #1;
            fifo_count = thr;
            if (!t[0]) begin
                repeat (12) @(posedge clk);
                chk_rdy(pol);
                for (int k = 1; k <= thr; k++) begin
                    rd_chk();
                    chk_rdy((k == thr) ? pol : ~pol);
                end
            end else begin
                pulse_w(pol, w);
                check(BUS_W'(w), continuous_mode ? 12'h00a : BUS_W'(OSC_HALF_CYC));
                w = 0;
                repeat (40) begin
                    @(posedge clk);
                    w += (sample_ready_out === pol);
                end
                check(BUS_W'(w), 12'h000);
                repeat (thr - 5'h01) rd_chk();
                fork
                    rd_chk();
                    pulse_w(pol, w);
                join
                check(BUS_W'(w), continuous_mode ? 12'h00a : BUS_W'(OSC_HALF_CYC));
            end
        end
        do_reset();
        fifo_count = 5'h00;
        wr_reg(1'b1, 10'h040);
        i_ahr_host_model.dir_mode = 1'b1;
        rd_chk();
        wr_reg(1'b0, 10'h2a5);
        close_out();
    end
endmodule
